/* File: src/wwd_top.sv */
// windowed watchdog with apb register access
// assumes apb master in the ref_clk domain; sys_rst covers the system reset it requests
// Operation
// - 12-bit down counter, 3-bit prescaler
// - underflow requests system reset
// - reload above delta requests reset
// - debug halt freezes the counter
// - protection ignores configuration writes
// - count clock from internal or external
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module wwd_top (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_speed_internal_osc,
  input wire logic low_speed_external_osc,
  input wire logic cpu_halted,
  output logic sys_rst_req
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [11:0] load;
    logic [11:0] delta;
    logic [2:0] pre;
    logic en;
    logic rst_en;
    logic dbg_hold;
    logic clk_sel;
    logic prot;
    logic [11:0] cnt;
    logic under_flag;
    logic early_flag;
    logic [3:0] pulse;
    logic req;
    logic [31:0] rdata;
  } wwd_st_t;

  wwd_st_t st_r;
  wwd_st_t st_nxt;
  logic tick;
  logic acc;
  logic wr;
  logic reload_req;
  logic restart;
  logic run;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = st_r.rdata;
  assign sys_rst_req = st_r.req;
  assign reload_req = wr && (paddr == wwd_pkg::OFS_CTRL)
    && pwdata[wwd_pkg::CTRL_RELOAD_BIT] && (pwdata[31:16] == wwd_pkg::CTRL_KEY);
  assign restart = reload_req || !st_r.en;
  assign run = st_r.en && !(st_r.dbg_hold && cpu_halted);

  wwd_tick u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .low_speed_internal_osc(low_speed_internal_osc),
    .low_speed_external_osc(low_speed_external_osc),
    .clk_sel(st_r.clk_sel),
    .pre_sel(st_r.pre),
    .restart(restart),
    .run(run),
    .tick(tick)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (st_r.pulse != 4'h0) begin
      st_nxt.pulse = st_r.pulse - 4'h1;
    end
    // register writes; protection blocks config but not reload
    if (wr && !st_r.prot) begin
      unique case (paddr)
        wwd_pkg::OFS_MODE: begin
          st_nxt.load = pwdata[wwd_pkg::MODE_LOAD_LSB +: 12];
          st_nxt.pre = pwdata[wwd_pkg::MODE_PRE_LSB +: 3];
          st_nxt.en = pwdata[wwd_pkg::MODE_EN_BIT];
          st_nxt.rst_en = pwdata[wwd_pkg::MODE_RSTEN_BIT];
          st_nxt.dbg_hold = pwdata[wwd_pkg::MODE_DBGHOLD_BIT];
          st_nxt.clk_sel = pwdata[wwd_pkg::MODE_CLKSEL_BIT];
          if (pwdata[wwd_pkg::MODE_EN_BIT] && !st_r.en) begin
            st_nxt.cnt = pwdata[wwd_pkg::MODE_LOAD_LSB +: 12];
          end
        end
        wwd_pkg::OFS_DELTA: begin
          st_nxt.delta = pwdata[11:0];
        end
        default: begin
        end
      endcase
    end
    // protection register stays writable so it can be unlocked
    if (wr && paddr == wwd_pkg::OFS_PROT) begin
      st_nxt.prot = (pwdata[15:0] != wwd_pkg::PROT_UNLOCK);
    end
    // status flags: write one to clear, a new event wins
    if (wr && paddr == wwd_pkg::OFS_STAT) begin
      if (pwdata[wwd_pkg::STAT_UNDER_BIT]) begin
        st_nxt.under_flag = 1'b0;
      end
      if (pwdata[wwd_pkg::STAT_EARLY_BIT]) begin
        st_nxt.early_flag = 1'b0;
      end
    end
    if (st_r.en) begin
      if (reload_req) begin
        if (st_r.cnt > st_r.delta) begin
          st_nxt.early_flag = 1'b1;
          if (st_r.rst_en) begin
            st_nxt.pulse = wwd_pkg::RST_PULSE_CYC;
          end
        end
        st_nxt.cnt = st_r.load;
      end else if (tick) begin
        if (st_r.cnt == 12'h000) begin
          st_nxt.under_flag = 1'b1;
          st_nxt.cnt = st_r.load;
          if (st_r.rst_en) begin
            st_nxt.pulse = wwd_pkg::RST_PULSE_CYC;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 12'h001;
        end
      end
    end
    // request kept in its own flop: a multi-bit count change must not glitch it
    st_nxt.req = (st_nxt.pulse != 4'h0);
    // read data registered at the setup cycle, valid in access
    st_nxt.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        wwd_pkg::OFS_MODE: begin
          st_nxt.rdata = {12'h000, st_r.clk_sel, st_r.dbg_hold, st_r.rst_en, st_r.en,
            1'b0, st_r.pre, st_r.load};
        end
        wwd_pkg::OFS_DELTA: begin
          st_nxt.rdata = {20'h00000, st_r.delta};
        end
        wwd_pkg::OFS_PROT: begin
          st_nxt.rdata = {31'h0000_0000, st_r.prot};
        end
        wwd_pkg::OFS_STAT: begin
          st_nxt.rdata = {15'h0000, st_r.prot, st_r.cnt, 2'h0, st_r.early_flag,
            st_r.under_flag};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end else if (acc) begin
      st_nxt.rdata = st_r.rdata;
    end
  end

  // ---------------------------------------------------------------
  // registers; sys_rst returns every setting to default
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.load <= wwd_pkg::LOAD_RST;
      st_r.delta <= wwd_pkg::DELTA_RST;
      st_r.pre <= wwd_pkg::PRE_RST;
      st_r.rst_en <= wwd_pkg::RSTEN_RST;
      st_r.cnt <= wwd_pkg::LOAD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: src/wwd_pkg.sv */
// package for the windowed watchdog: register offsets, field layout, reset values
// assumes an apb slave with 32-bit data, one aligned word per register
package wwd_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_MODE = 12'h004;
  localparam logic [11:0] OFS_DELTA = 12'h008;
  localparam logic [11:0] OFS_PROT = 12'h00c;
  localparam logic [11:0] OFS_STAT = 12'h010;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int CTRL_RELOAD_BIT = 0;
  localparam logic [15:0] CTRL_KEY = 16'h5fa0;
  localparam int MODE_LOAD_LSB = 0;
  localparam int MODE_PRE_LSB = 12;
  localparam int MODE_EN_BIT = 16;
  localparam int MODE_RSTEN_BIT = 17;
  localparam int MODE_DBGHOLD_BIT = 18;
  localparam int MODE_CLKSEL_BIT = 19;
  localparam int STAT_UNDER_BIT = 0;
  localparam int STAT_EARLY_BIT = 1;
  localparam int STAT_CNT_LSB = 4;
  localparam int STAT_PROT_BIT = 16;
  localparam logic [15:0] PROT_UNLOCK = 16'h35ca;

  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [11:0] LOAD_RST = 12'hfff;
  localparam logic [11:0] DELTA_RST = 12'hfff;
  localparam logic [2:0] PRE_RST = 3'h0;
  localparam logic RSTEN_RST = 1'b1;
  localparam logic [3:0] RST_PULSE_CYC = 4'h8;

endpackage

/* File: src/wwd_tick.sv */
// tick generator: chooses the low-speed source and divides it by a power of two
// assumes oscillator inputs are levels synchronous to ref_clk
`timescale 1ns/1ps
module wwd_tick (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic low_speed_internal_osc,
  input wire logic low_speed_external_osc,
  input wire logic clk_sel,
  input wire logic [2:0] pre_sel,
  input wire logic restart,
  input wire logic run,
  output logic tick
);
  typedef struct packed {
    logic osc_d;
    logic [7:0] div;
  } wwd_tick_st_t;

  wwd_tick_st_t st_r;
  wwd_tick_st_t st_nxt;
  logic osc;
  logic edge_seen;

  always_comb begin
    osc = clk_sel ? low_speed_external_osc : low_speed_internal_osc;
    edge_seen = osc & ~st_r.osc_d;
    st_nxt = st_r;
    st_nxt.osc_d = osc;
    tick = 1'b0;
    if (restart) begin
      st_nxt.div = 8'h00;
    end else if (run && edge_seen) begin
      // prescale 2^pre_sel source edges per decrement
      if (st_r.div >= ((8'h01 << pre_sel) - 8'h01)) begin
        st_nxt.div = 8'h00;
        tick = 1'b1;
      end else begin
        st_nxt.div = st_r.div + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

/* File: verif/wwd_checker.sv */
// checker for wwd_top: bus answer and reset-request relations
// assumes it is bound onto wwd_top and sees its ports only
`timescale 1ns/1ps
module wwd_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sys_rst_req
);
  // ----
  // properties
  // ----
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  pulse_len_a: assert property ($rose(sys_rst_req) |-> sys_rst_req [*8] ##1 !sys_rst_req)
    else $error("reset request not 8 cycles");
  pulse_min_a: assert property ($fell(sys_rst_req) |-> $past(sys_rst_req, 8))
    else $error("reset request too short");
  reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !sys_rst_req)
    else $error("reset request during reset");
  access_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  no_error_a: assert property (psel |-> !pslverr)
    else $error("error response seen");
  idle_rdata_a: assert property (!psel && !$past(psel) |-> prdata == 32'h0)
    else $error("read data outside transfer");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h014 |->
    prdata == 32'h0) else $error("unmapped read not zero");
  stat_rsvd_a: assert property (psel && penable && !pwrite && paddr == 12'h010 |->
    prdata[31:17] == 15'h0) else $error("status upper bits set");
endmodule

bind wwd_top wwd_checker u_wwd_checker (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sys_rst_req(sys_rst_req));

/* File: verif/windowed_watchdog_timer_bench.sv */
// bench for wwd_top: apb master tasks, slow oscillators, self-checks
// assumes wwd_top and the bound wwd_checker are compiled before it
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module windowed_watchdog_timer_bench;
  // ----
  // stimulus
  // ----
  logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, cpu_halted = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, a;
  logic pready, pslverr, sys_rst_req, osc_i = 0, osc_e = 0, run_i = 1, run_e = 0;
  logic [1:0] dv = 0;
  int n_fail = 0, samples_checked = 0, seed = 45122, n;
  always #12.5 ref_clk = ~ref_clk;
  // slow sources: one rising edge per 4 cycles while running
  always @(posedge ref_clk) begin
    dv <= dv + 2'h1;
    osc_i <= run_i & dv[1];
    osc_e <= run_e & dv[1];
  end
  wwd_top u_wwd_top (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_speed_internal_osc(osc_i), .low_speed_external_osc(osc_e),
    .cpu_halted(cpu_halted), .sys_rst_req(sys_rst_req));
  function int uf(input int l, input int p);
    return (l + 1) * (4 << p);
  endfunction
  task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (i >= 16) begin
      n_fail++;
      results();
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk_rd(input logic [11:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0);
    `CHK("rdata", e, q)
  endtask
  task automatic wait_req(input int lim);
    n = 0;
    while (sys_rst_req !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
  task results();
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // sequence
  // ----
  initial begin
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_rd(wwd_pkg::OFS_MODE, 32'h0002_0fff);
    chk_rd(wwd_pkg::OFS_DELTA, 32'h0000_0fff);
    chk_rd(wwd_pkg::OFS_STAT, 32'h0000_fff0);
    chk_rd(12'h014, 32'h0);
    a = $random(seed);
    cpu_halted <= a[0];
    xfer(1'b1, wwd_pkg::OFS_MODE, 32'h0003_1010);
    wait_req(400);
    cpu_halted <= 1'b0;
    `CHK("uf_time", 1'b1, n >= uf(16, 1) - 12 && n <= uf(16, 1) + 14)
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("uf_flag", 1'b1, q[0])
    xfer(1'b1, wwd_pkg::OFS_STAT, 32'h3);
    xfer(1'b1, wwd_pkg::OFS_DELTA, 32'h4);
    repeat (6) @(posedge ref_clk);
    xfer(1'b1, wwd_pkg::OFS_CTRL, 32'h5fa0_0001);
    wait_req(4);
    `CHK("early", 1'b1, n < 4)
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("early_flag", 1'b1, q[1])
    `CHK("uf_clear", 1'b0, q[0])
    repeat (12) @(posedge ref_clk);
    for (int i = 0; i < 40 && q[15:4] > 12'h004; i++) xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    xfer(1'b1, wwd_pkg::OFS_CTRL, 32'h5fa0_0001);
    wait_req(20);
    `CHK("in_window", 20, n)
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("reloaded", 1'b1, q[15:4] >= 12'h00d)
    xfer(1'b1, wwd_pkg::OFS_MODE, 32'h0007_1010);
    cpu_halted <= 1'b1;
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    a = q;
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("frozen", a[15:4], q[15:4])
    cpu_halted <= 1'b0;
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("resumed", 1'b1, q[15:4] != a[15:4])
    a = $random(seed);
    if (a[15:0] == 16'h35ca) a = 32'h0;
    xfer(1'b1, wwd_pkg::OFS_PROT, a);
    xfer(1'b1, wwd_pkg::OFS_MODE, 32'h0);
    chk_rd(wwd_pkg::OFS_MODE, 32'h0007_1010);
    chk_rd(wwd_pkg::OFS_PROT, 32'h1);
    xfer(1'b1, wwd_pkg::OFS_PROT, 32'h0000_35ca);
    xfer(1'b1, wwd_pkg::OFS_MODE, 32'h0009_1010);
    chk_rd(wwd_pkg::OFS_MODE, 32'h0009_1010);
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    a = q;
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("ext_idle", a[15:4], q[15:4])
    run_e <= 1'b1;
    repeat (40) @(posedge ref_clk);
    xfer(1'b0, wwd_pkg::OFS_STAT, 32'h0);
    `CHK("ext_runs", 1'b1, q[15:4] != a[15:4])
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk_rd(wwd_pkg::OFS_MODE, 32'h0002_0fff);
    chk_rd(wwd_pkg::OFS_STAT, 32'h0000_fff0);
    results();
  end
endmodule
